// [common/strobe_timing_map.svh]
/*
  register offsets, reset values and field positions of the strobe
  timing block. assumes a 32-bit classic wishbone slave in which every
  register takes one aligned word and narrower data sits in the low bits.
*/
`ifndef STROBE_TIMING_MAP_SVH
`define STROBE_TIMING_MAP_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFF_READ_NEGATE   8'h00
`define OFF_LEAD_EXTEND   8'h04
`define OFF_TRAIL_EXTEND  8'h08
`define OFF_ACCESS_STATUS 8'h0C

// ------------------------------------------------------------
// reset values and widths
// ------------------------------------------------------------
`define RST_CTRL          8'h00
`define RST_ADDR          24'h000000
`define RST_AREA          3'h0
`define ZERO_WORD         32'h00000000
`define AREA_COUNT        8
`define ADDR_WIDTH        24

// ------------------------------------------------------------
// access_status fields
// ------------------------------------------------------------
`define STAT_BUSY_BIT     0
`define STAT_PHASE_BIT    1
`define STAT_STATE_LSB    4
`define STAT_STATE_MSB    6
`define STAT_AREA_LSB     8
`define STAT_AREA_MSB     10

`endif

// [common/strobe_timing_pkg.sv]
/*
  types shared by the strobe timing block and its access sequencer.
  does not include strobe_timing_map.svh; state codes and widths are written here.
*/
package strobe_timing_pkg;

  // gray coded along idle, lead, t1, t2, t3, trail
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_LEAD  = 3'h1,
    ST_T1    = 3'h3,
    ST_T2    = 3'h2,
    ST_T3    = 3'h6,
    ST_TRAIL = 3'h7
  } acc_state_e;

  typedef logic [2:0] area_t;
  typedef logic [7:0] area_mask_t;

endpackage : strobe_timing_pkg

// [core/access_sequencer.sv]
/*
  state sequencer of one basic bus interface access. each bus state
  spans two clock cycles, one per half-state. assumes start is only
  given while busy is low, and that the option inputs are stable then.
*/
`timescale 1ns/1ps
`include "strobe_timing_map.svh"

module access_sequencer (
  // clock and reset
  input  wire logic                           clk_in,
  input  wire logic                           rst_in,
  // access request
  input  wire logic                           start_in,
  input  wire logic                           lead_in,
  input  wire logic                           trail_in,
  input  wire logic                           three_state_in,
  // sequence state
  output strobe_timing_pkg::acc_state_e       state_out,
  output logic                                phase_out,
  output logic                                last_normal_out,
  output logic                                done_out
);
  import strobe_timing_pkg::*;

  acc_state_e state_ff;
  acc_state_e nxt_state;
  logic       phase_ff;
  logic       lead_ff;
  logic       trail_ff;
  logic       three_ff;
  logic       state_end;

  // a state ends at the close of its second half
  assign state_end       = phase_ff;
  assign last_normal_out = (state_ff == ST_T3) ||
                           (state_ff == ST_T2 && !three_ff);
  assign state_out       = state_ff;
  assign phase_out       = phase_ff;
  assign done_out        = state_end &&
                           ((state_ff == ST_TRAIL) ||
                            (last_normal_out && !trail_ff));

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start_in) begin
          nxt_state = lead_in ? ST_LEAD : ST_T1;  // [R5] [R7] [R9]
        end
      end
      ST_LEAD: begin
        if (state_end) begin
          nxt_state = ST_T1;
        end
      end
      ST_T1: begin
        if (state_end) begin
          nxt_state = ST_T2;
        end
      end
      ST_T2: begin
        if (state_end) begin
          nxt_state = three_ff ? ST_T3 : (trail_ff ? ST_TRAIL : ST_IDLE);
        end
      end
      ST_T3: begin
        if (state_end) begin
          nxt_state = trail_ff ? ST_TRAIL : ST_IDLE;  // [R6] [R7] [R9]
        end
      end
      ST_TRAIL: begin
        if (state_end) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_ff <= ST_IDLE;
      phase_ff <= 1'b0;
      lead_ff  <= 1'b0;
      trail_ff <= 1'b0;
      three_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      phase_ff <= (state_ff == ST_IDLE) ? 1'b0 : !phase_ff;
      if (state_ff == ST_IDLE && start_in) begin
        lead_ff  <= lead_in;
        trail_ff <= trail_in;
        three_ff <= three_state_in;
      end
    end
  end

endmodule : access_sequencer

// [core/ext_bus_strobe_timing_ctrl.sv]
/*
  per-area strobe timing of the external bus controller: read strobe
  negation point and extra chip select / address states before and after
  a basic bus interface access, with a classic wishbone register port.
  assumes the bus controller gives one access at a time, with its area,
  direction and address, and that a clock cycle is half a bus state.
*/
// Our own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "strobe_timing_map.svh"

// How it works
// R1 - bit clear: read strobe ends at cycle end
// R2 - bit set: read strobe ends half-state early
// R3 - early areas: device data timing half-state earlier
// R4 - early-negation bits reset zero, software read/write
// R5 - lead bit adds select/address-only state first
// R6 - trail bit adds select/address-only state last
// R7 - clear extension bit adds no extra state
// R8 - extension registers eight bits, reset zero
// R9 - lead, normal, trail; select/address held stable
module ext_bus_strobe_timing_ctrl (
  // clock and reset
  input  wire logic                          core_clk_in,
  input  wire logic                          rst_in,
  // wishbone slave
  input  wire logic                          wb_cyc_in,
  input  wire logic                          wb_stb_in,
  input  wire logic                          wb_we_in,
  input  wire logic [7:0]                    wb_adr_in,
  input  wire logic [3:0]                    wb_sel_in,
  input  wire logic [31:0]                   wb_dat_in,
  output logic      [31:0]                   wb_dat_out,
  output logic                               wb_ack_out,
  // access request from the bus controller
  input  wire logic                          acc_start_in,
  input  strobe_timing_pkg::area_t           acc_area_in,
  input  wire logic                          acc_read_in,
  input  wire logic                          acc_three_state_in,
  input  wire logic [23:0]                   acc_addr_in,
  output logic                               acc_busy_out,
  output logic                               acc_done_out,
  // external bus pins
  output logic      [7:0]                    area_select_n_out,
  output logic      [23:0]                   ext_addr_out,
  output logic                               rd_n_out,
  output logic                               wr_n_out
);
  import strobe_timing_pkg::*;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic area_bit(input area_mask_t mask,
                                    input area_t area);
    area_bit = mask[area];
  endfunction : area_bit

  function automatic logic [31:0] low_byte(input area_mask_t value);
    low_byte = {24'h000000, value};
  endfunction : low_byte

  // ------------------------------------------------------------
  // registers and wires
  // ------------------------------------------------------------
  area_mask_t  read_negate_ctrl_ff;
  area_mask_t  lead_extend_ctrl_ff;
  area_mask_t  trail_extend_ctrl_ff;
  logic        ack_ff;
  logic [31:0] dat_ff;
  area_t       area_ff;
  logic        read_ff;
  logic        early_ff;
  logic [23:0] addr_ff;
  logic [7:0]  select_n_ff;
  logic        rd_n_ff;
  logic        wr_n_ff;
  logic        nxt_rd_n;
  logic        nxt_wr_n;
  logic [7:0]  nxt_select_n;

  acc_state_e  seq_state;
  logic        seq_phase;
  logic        seq_last;
  logic        seq_done;

  wire         bus_req     = wb_cyc_in && wb_stb_in;
  wire         wr_commit   = bus_req && wb_we_in && ack_ff && wb_sel_in[0];
  wire         hit_negate  = (wb_adr_in == `OFF_READ_NEGATE);
  wire         hit_lead    = (wb_adr_in == `OFF_LEAD_EXTEND);
  wire         hit_trail   = (wb_adr_in == `OFF_TRAIL_EXTEND);
  wire         hit_status  = (wb_adr_in == `OFF_ACCESS_STATUS);
  wire         seq_idle    = (seq_state == ST_IDLE);
  wire         take_access = acc_start_in && seq_idle;
  wire         in_normal   = (seq_state == ST_T1) ||
                             (seq_state == ST_T2) ||
                             (seq_state == ST_T3);
  wire         in_extra    = (seq_state == ST_LEAD) ||
                             (seq_state == ST_TRAIL);

  // ------------------------------------------------------------
  // status word
  // ------------------------------------------------------------
  logic [31:0] status_word;
  always_comb begin
    status_word = `ZERO_WORD;
    status_word[`STAT_BUSY_BIT] = !seq_idle;
    status_word[`STAT_PHASE_BIT] = seq_phase;
    status_word[`STAT_STATE_MSB:`STAT_STATE_LSB] = seq_state;
    status_word[`STAT_AREA_MSB:`STAT_AREA_LSB] = area_ff;
  end

  // unmapped offsets read as zero and writes to them are dropped
  wire [31:0] rd_mux = hit_negate ? low_byte(read_negate_ctrl_ff) :
                       hit_lead   ? low_byte(lead_extend_ctrl_ff) :
                       hit_trail  ? low_byte(trail_extend_ctrl_ff) :
                       hit_status ? status_word : `ZERO_WORD;

  // ------------------------------------------------------------
  // wishbone slave: ack one cycle after the request, dropped after
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ack_ff <= 1'b0;
      dat_ff <= `ZERO_WORD;
    end else begin
      ack_ff <= bus_req && !ack_ff;
      if (bus_req && !ack_ff) begin
        dat_ff <= rd_mux;
      end
    end
  end

  // control registers; a change mid-access applies to the next one
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      read_negate_ctrl_ff  <= `RST_CTRL;  // [R4]
      lead_extend_ctrl_ff  <= `RST_CTRL;  // [R8]
      trail_extend_ctrl_ff <= `RST_CTRL;  // [R8]
    end else if (wr_commit) begin
      if (hit_negate) begin
        read_negate_ctrl_ff <= wb_dat_in[7:0];  // [R4]
      end
      if (hit_lead) begin
        lead_extend_ctrl_ff <= wb_dat_in[7:0];  // [R8]
      end
      if (hit_trail) begin
        trail_extend_ctrl_ff <= wb_dat_in[7:0];  // [R8]
      end
    end
  end

  assign wb_ack_out = ack_ff;
  assign wb_dat_out = dat_ff;

  // ------------------------------------------------------------
  // access sequencer
  // ------------------------------------------------------------
  access_sequencer u_seq (
    .clk_in          (core_clk_in),
    .rst_in          (rst_in),
    .start_in        (take_access),
    .lead_in         (area_bit(lead_extend_ctrl_ff, acc_area_in)),
    .trail_in        (area_bit(trail_extend_ctrl_ff, acc_area_in)),
    .three_state_in  (acc_three_state_in),
    .state_out       (seq_state),
    .phase_out       (seq_phase),
    .last_normal_out (seq_last),
    .done_out        (seq_done)
  );

  // area, direction, address and negation choice are caught at the
  // start so that select and address cannot move inside an access
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      area_ff  <= `RST_AREA;
      read_ff  <= 1'b0;
      early_ff <= 1'b0;
      addr_ff  <= `RST_ADDR;
    end else if (take_access) begin
      area_ff  <= acc_area_in;
      read_ff  <= acc_read_in;
      early_ff <= area_bit(read_negate_ctrl_ff, acc_area_in);  // [R1] [R2]
      addr_ff  <= acc_addr_in;  // [R9]
    end
  end

  // ------------------------------------------------------------
  // strobe and select shaping
  // ------------------------------------------------------------
  // select covers lead, normal and trail states alike
  always_comb begin
    nxt_select_n = '1;
    if (in_normal || in_extra) begin
      nxt_select_n[area_ff] = 1'b0;  // [R5] [R6] [R9]
    end
  end

  // read strobe opens in the second half of t1; its last half-state is
  // dropped for early-negation areas, so the device must drive data
  // half a state sooner
  always_comb begin
    nxt_rd_n = 1'b1;
    if (read_ff && in_normal) begin
      if (seq_state == ST_T1 && !seq_phase) begin
        nxt_rd_n = 1'b1;
      end else if (seq_last && seq_phase && early_ff) begin
        nxt_rd_n = 1'b1;  // [R2] [R3]
      end else begin
        nxt_rd_n = 1'b0;  // [R1]
      end
    end
  end

  // write strobe spans t2 up to the first half of the last state
  always_comb begin
    nxt_wr_n = 1'b1;
    if (!read_ff && in_normal && seq_state != ST_T1) begin
      nxt_wr_n = (seq_last && seq_phase);
    end
  end

  // no strobe is driven in an extra state: in_normal is low there
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      select_n_ff <= '1;
      rd_n_ff     <= 1'b1;
      wr_n_ff     <= 1'b1;
    end else begin
      select_n_ff <= nxt_select_n;
      rd_n_ff     <= nxt_rd_n;  // [R1] [R2]
      wr_n_ff     <= nxt_wr_n;  // [R6]
    end
  end

  assign area_select_n_out = select_n_ff;
  assign ext_addr_out      = addr_ff;
  assign rd_n_out          = rd_n_ff;
  assign wr_n_out          = wr_n_ff;
  assign acc_busy_out      = !seq_idle;
  assign acc_done_out      = seq_done;

endmodule : ext_bus_strobe_timing_ctrl

// [test/ext_bus_strobe_timing_ctrl_tb.sv]
/* register and access bench of the strobe timing block.
   assumes the one-cycle wishbone ack and pins lagging state by one. */
`timescale 1ns/1ps
module ext_bus_strobe_timing_ctrl_tb;
  import strobe_timing_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
  logic [7:0] wb_adr_in = 8'h00;
  logic [3:0] wb_sel_in = 4'hF;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out;
  logic wb_ack_out, acc_busy_out, acc_done_out, rd_n_out, wr_n_out;
  logic acc_start_in = 1'b0, acc_read_in = 1'b0, acc_three_state_in = 1'b0;
  area_t acc_area_in = 3'h0;
  logic [23:0] acc_addr_in = 24'h0, ext_addr_out;
  logic [7:0] area_select_n_out, first_sel;
  logic steady;
  int sel_c, str_c, lead_g, last_s, errors = 0, checked = 0;
  logic [7:0] cfg [3] = '{8'h22, 8'h84, 8'h2C};
  int ca [7] = '{0, 1, 2, 7, 5, 3, 4};
  bit crd [7] = '{1, 1, 1, 0, 1, 1, 1};
  bit cth [7] = '{0, 0, 1, 0, 1, 1, 1};
  logic [31:0] d;
  int e, l, t, n, a;

  ext_bus_strobe_timing_ctrl i_dut (.core_clk_in, .rst_in, .wb_cyc_in,
    .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out,
    .wb_ack_out, .acc_start_in, .acc_area_in, .acc_read_in,
    .acc_three_state_in, .acc_addr_in, .acc_busy_out, .acc_done_out,
    .area_select_n_out, .ext_addr_out, .rd_n_out, .wr_n_out);
  ext_device_model i_dev (.clk_in(core_clk_in), .rst_in(rst_in),
    .sel_n_in(area_select_n_out), .addr_in(ext_addr_out),
    .rd_n_in(rd_n_out), .wr_n_in(wr_n_out), .sel_cycles_out(sel_c),
    .strobe_cycles_out(str_c), .lead_gap_out(lead_g),
    .last_strobe_out(last_s), .first_sel_out(first_sel),
    .addr_ok_out(steady));

  always #25 core_clk_in = ~core_clk_in;

  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task automatic close_out;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  task automatic check_word(string nm, logic [31:0] ex, logic [31:0] got);
    checked++;
    if (got !== ex) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask : check_word

  task automatic check_count(string nm, int ex, int got);
    checked++;
    if (got != ex) begin
      errors++;
      $display("BAD %s expected %0d seen %0d", nm, ex, got);
    end
  endtask : check_count

  task automatic wait_for(input bit on_done);
    int w;
    w = 0;
    do begin
      @(posedge core_clk_in);
      w++;
      if (w > 50) begin
        errors++;
        close_out();
      end
    end while ((on_done ? acc_done_out : wb_ack_out) !== 1'b1);
  endtask : wait_for

  task automatic wb_io(logic [7:0] adr, logic we, logic [31:0] dat,
                       output logic [31:0] rd);
    @(posedge core_clk_in);
    {wb_cyc_in, wb_stb_in, wb_we_in} <= {2'b11, we};
    wb_adr_in <= adr;
    wb_dat_in <= dat;
    wait_for(1'b0);
    rd = wb_dat_out;
    {wb_cyc_in, wb_stb_in, wb_we_in} <= 3'b000;
  endtask : wb_io

  // ----------------------------------------------------------
  // sequence
  // ----------------------------------------------------------
  initial begin
    repeat (20) @(posedge core_clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      wb_io(8'(4 * i), 1'b0, 32'h0, d);
      check_word("reset", 32'h0, d);
      wb_io(8'(4 * i), 1'b1, {24'h0, cfg[i]}, d);
      wb_io(8'(4 * i), 1'b0, 32'h0, d);
      check_word("readback", {24'h0, cfg[i]}, d);
    end
    // unmapped place reads zero and swallows writes
    wb_io(8'h10, 1'b1, 32'hFF, d);
    wb_io(8'h10, 1'b0, 32'h0, d);
    check_word("unmapped", 32'h0, d);
    // a write with byte lane 0 off is acked but leaves the register alone
    wb_sel_in <= 4'hE;
    wb_io(8'h00, 1'b1, 32'hFF, d);
    wb_sel_in <= 4'hF;
    wb_io(8'h00, 1'b0, 32'h0, d);
    check_word("lane", {24'h0, cfg[0]}, d);
    wb_io(8'h0C, 1'b0, 32'h0, d);
    check_word("idle status", 32'h0, d);
    for (int i = 0; i < 7; i++) begin
      a = ca[i];
      e = cfg[0][a];
      l = cfg[1][a];
      t = cfg[2][a];
      n = 2 + cth[i];
      @(posedge core_clk_in);
      {acc_start_in, acc_read_in, acc_three_state_in} <= {1'b1, crd[i], cth[i]};
      acc_area_in <= area_t'(a);
      acc_addr_in <= 24'h5A0000 + 24'(i);
      @(posedge core_clk_in);
      acc_start_in <= 1'b0;
      wait_for(1'b1);
      repeat (3) @(posedge core_clk_in);
      check_count("select", 2 * (l + n + t), sel_c);
      check_count("strobe", crd[i] ? 2 * n - 1 - e : 2 * n - 3, str_c);
      check_count("lead", crd[i] ? 2 * l + 1 : 2 * l + 2, lead_g);
      check_count("tail", crd[i] ? 2 * t + e : 2 * t + 1, sel_c - 1 - last_s);
      check_word("area", {24'h0, ~(8'h01 << a)}, {24'h0, first_sel});
      check_word("addr", 32'h5A0000 + i, {8'h0, ext_addr_out});
      check_word("steady", 32'h1, {31'h0, steady});
    end
    // idle again, with the last access's area (4) still latched
    wb_io(8'h0C, 1'b0, 32'h0, d);
    check_word("status", 32'h00000400, d);
    close_out();
  end
endmodule : ext_bus_strobe_timing_ctrl_tb

// [test/ext_device_model.sv]
/* external device on the bus: measures each selected period.
   assumes one area selected at a time, sampled on the rising clock. */
`timescale 1ns/1ps
module ext_device_model (
  // bus pins
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic [7:0]  sel_n_in,
  input wire logic [23:0] addr_in,
  input wire logic        rd_n_in,
  input wire logic        wr_n_in,
  // measurements
  output int              sel_cycles_out,
  output int              strobe_cycles_out,
  output int              lead_gap_out,
  output int              last_strobe_out,
  output logic [7:0]      first_sel_out,
  output logic            addr_ok_out
);
  int          k;
  logic [23:0] a0;
  always @(posedge clk_in) begin
    if (rst_in || sel_n_in === 8'hFF)
      k = 0;
    else begin
      if (k == 0) begin
        first_sel_out = sel_n_in;
        strobe_cycles_out = 0;
        addr_ok_out = 1'b1;
        a0 = addr_in;
      end
      if (addr_in !== a0)
        addr_ok_out = 1'b0;
      if (!rd_n_in || !wr_n_in) begin
        if (strobe_cycles_out == 0)
          lead_gap_out = k;
        strobe_cycles_out++;
        // data window closes at strobe rise, half state early if so set
        last_strobe_out = k;
      end
      k++;
      sel_cycles_out = k;
    end
  end
endmodule : ext_device_model

// [test/strobe_timing_asserts.sv]
/* port assertions of the strobe timing block.
   assumes binding into ext_bus_strobe_timing_ctrl. */
`timescale 1ns/1ps
module strobe_timing_asserts (
  // clock and reset
  input wire logic        core_clk_in,
  input wire logic        rst_in,
  // watched ports
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_ack_out,
  input wire logic        acc_start_in,
  input wire logic        acc_busy_out,
  input wire logic        acc_done_out,
  input wire logic [7:0]  area_select_n_out,
  input wire logic [23:0] ext_addr_out,
  input wire logic        rd_n_out,
  input wire logic        wr_n_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  AST_ACK_NEXT: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  AST_ONE_AREA: assert property ($countones(~area_select_n_out) <= 1)
    else $error("more than one area selected");
  AST_ADDR_STABLE: assert property ((area_select_n_out != 8'hFF) &&
    ($past(area_select_n_out) != 8'hFF) |-> $stable(ext_addr_out))
    else $error("address moved while selected");
  AST_STROBE_IN_SEL: assert property (!(rd_n_out && wr_n_out) |->
    area_select_n_out != 8'hFF)
    else $error("strobe outside select");
  AST_SEL_LEADS: assert property ($fell(rd_n_out && wr_n_out) |->
    $past(area_select_n_out) != 8'hFF)
    else $error("strobe fell with select");
  AST_DONE_RELEASE: assert property (acc_done_out |-> ##2
    (area_select_n_out == 8'hFF) && rd_n_out && wr_n_out)
    else $error("pins not released after done");
  AST_BUSY_TAKE: assert property (acc_start_in && !acc_busy_out |=> acc_busy_out)
    else $error("start not taken");
  AST_NO_BOTH: assert property (rd_n_out || wr_n_out)
    else $error("both strobes low");
endmodule : strobe_timing_asserts

bind ext_bus_strobe_timing_ctrl strobe_timing_asserts i_chk (.core_clk_in,
  .rst_in, .wb_cyc_in, .wb_stb_in, .wb_ack_out, .acc_start_in, .acc_busy_out,
  .acc_done_out, .area_select_n_out, .ext_addr_out, .rd_n_out, .wr_n_out);
